// ### core/cis_defs.svh
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH
// comparator pair select codes (positive/negative)
`define CIS_PAIR_0_1 3'h0
`define CIS_PAIR_0_2 3'h1
`define CIS_PAIR_1_0 3'h2
`define CIS_PAIR_1_2 3'h3
// dedicated comparator pin indices
`define CIS_PIN_ZERO 4'h0
`define CIS_PIN_ONE  4'h1
`define CIS_PIN_TWO  4'h2
// interrupt edge mode codes
`define CIS_EDGE_TOGGLE 2'h0
`define CIS_EDGE_NONE   2'h1
`define CIS_EDGE_FALL   2'h2
`define CIS_EDGE_RISE   2'h3
// number of converter input pins
`define CIS_CONV_PINS   32'h0000000B
`endif

// ### core/cis_pkg.sv
package cis_pkg;
   typedef struct packed {
      logic [1:0]  sync;
      logic        result;
      logic        pend;
      logic        neg_sub;
      logic [3:0]  pos_sel;
      logic [3:0]  neg_sel;
   } cis_state_t;
endpackage

// ### core/cis_comparator_input_select.sv
`timescale 1ns/100ps
// Overview of operation
// - result high when positive above negative
// - dedicated comparator interrupt request output
// - software picks rise, fall or toggle
// - substitute enabled, converter off: channel picks negative
// - otherwise a dedicated pin is negative
// - pair select decodes 0/1,0/2,1/0,1/2
// - substitution only for single-ended channels
`include "cis_defs.svh"
module cis_comparator_input_select
   import cis_pkg::*;
#(
   parameter int unsigned CONV_PINS = `CIS_CONV_PINS                  // converter input pins, single-ended
)
(
   input  wire logic        core_clk,                          // system clock
   input  wire logic        rst_b,                             // async reset, active low
   input  wire logic        comparator_raw,                    // analog comparator output, async
   input  wire logic        negative_input_substitute_enable,  // multiplexer substitution enable
   input  wire logic        converter_enable,                  // converter enabled
   input  wire logic [5:0]  converter_channel_select,          // converter channel select
   input  wire logic [2:0]  comparator_pair_select,            // dedicated pin pair select
   input  wire logic [1:0]  irq_edge_mode,                     // interrupt edge mode
   input  wire logic        irq_clear,                         // clear pending flag, pulse
   output logic             comparator_result,                 // synchronised result
   output logic             comparator_irq,                    // pending comparator interrupt
   output logic             negative_from_converter,           // negative input substituted
   output logic [3:0]       positive_pin_sel,                  // positive pin index 0..1
   output logic [3:0]       negative_pin_sel                   // negative: 0..2 pin, else converter pin
);
   cis_state_t s_r;
   cis_state_t s_nxt;
   logic       edge_hit;
   localparam logic [5:0] SE_LAST = 6'(CONV_PINS - 32'h1);              // highest single-ended channel

   always_comb begin
      s_nxt        = s_r;
      s_nxt.sync   = {s_r.sync[0], comparator_raw};
      s_nxt.result = s_r.sync[1];
      unique case (irq_edge_mode)
         `CIS_EDGE_RISE:   edge_hit = s_r.sync[1] & ~s_r.result;
         `CIS_EDGE_FALL:   edge_hit = ~s_r.sync[1] & s_r.result;
         `CIS_EDGE_TOGGLE: edge_hit = s_r.sync[1] ^ s_r.result;
         `CIS_EDGE_NONE:   edge_hit = 1'h0;
      endcase
      // set wins over clear
      s_nxt.pend = edge_hit | (s_r.pend & ~irq_clear);
      unique case (comparator_pair_select)
         `CIS_PAIR_0_1: begin
            s_nxt.pos_sel = `CIS_PIN_ZERO;
            s_nxt.neg_sel = `CIS_PIN_ONE;
         end
         `CIS_PAIR_0_2: begin
            s_nxt.pos_sel = `CIS_PIN_ZERO;
            s_nxt.neg_sel = `CIS_PIN_TWO;
         end
         `CIS_PAIR_1_0: begin
            s_nxt.pos_sel = `CIS_PIN_ONE;
            s_nxt.neg_sel = `CIS_PIN_ZERO;
         end
         `CIS_PAIR_1_2: begin
            s_nxt.pos_sel = `CIS_PIN_ONE;
            s_nxt.neg_sel = `CIS_PIN_TWO;
         end
         default: begin
            s_nxt.pos_sel = `CIS_PIN_ZERO;
            s_nxt.neg_sel = `CIS_PIN_ONE;
         end
      endcase
      s_nxt.neg_sub = 1'h0;
      if (negative_input_substitute_enable && !converter_enable &&
          converter_channel_select <= SE_LAST) begin
         s_nxt.neg_sub = 1'h1;
         s_nxt.neg_sel = converter_channel_select[3:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign comparator_result       = s_r.result;
   assign comparator_irq          = s_r.pend;
   assign negative_from_converter = s_r.neg_sub;
   assign positive_pin_sel        = s_r.pos_sel;
   assign negative_pin_sel        = s_r.neg_sel;

   property p_result_follows;
      @(posedge core_clk) disable iff (!rst_b)
      1'b1 |-> ##3 (comparator_result == $past(comparator_raw, 3));
   endproperty
   a_result_follows: assert property (p_result_follows) else $error("result lags wrong");

   property p_rise_irq;
      @(posedge core_clk) disable iff (!rst_b)
      (irq_edge_mode == `CIS_EDGE_RISE && s_r.sync[1] && !s_r.result) |=> comparator_irq;
   endproperty
   a_rise_irq: assert property (p_rise_irq) else $error("rise missed");

   property p_irq_hold;
      @(posedge core_clk) disable iff (!rst_b)
      (comparator_irq && !irq_clear) |=> comparator_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("pending lost");

   property p_irq_source;
      @(posedge core_clk) disable iff (!rst_b)
      $rose(comparator_irq) |-> $past(s_r.sync[1]) != $past(s_r.result);
   endproperty
   a_irq_source: assert property (p_irq_source) else $error("irq without edge");

   property p_sub;
      @(posedge core_clk) disable iff (!rst_b)
      (negative_input_substitute_enable && !converter_enable && converter_channel_select <= SE_LAST)
      |=> (negative_from_converter && negative_pin_sel == $past(converter_channel_select[3:0]));
   endproperty
   a_sub: assert property (p_sub) else $error("substitution missing");

   property p_no_sub;
      @(posedge core_clk) disable iff (!rst_b)
      (converter_enable || !negative_input_substitute_enable) |=> !negative_from_converter;
   endproperty
   a_no_sub: assert property (p_no_sub) else $error("bad substitution");

   property p_pair;
      @(posedge core_clk) disable iff (!rst_b)
      (comparator_pair_select == `CIS_PAIR_1_2 && !negative_input_substitute_enable)
      |=> (positive_pin_sel == 4'h1 && negative_pin_sel == 4'h2);
   endproperty
   a_pair: assert property (p_pair) else $error("pair decode wrong");

   property p_diff_ch;
      @(posedge core_clk) disable iff (!rst_b)
      (converter_channel_select > SE_LAST) |=> !negative_from_converter;
   endproperty
   a_diff_ch: assert property (p_diff_ch) else $error("differential substituted");

   property p_fall_irq;
      @(posedge core_clk) disable iff (!rst_b)
      (irq_edge_mode == `CIS_EDGE_FALL && !s_r.sync[1] && s_r.result)
      |=> comparator_irq;
   endproperty
   a_fall_irq: assert property (p_fall_irq) else $error("fall missed");

   property p_toggle_irq;
      @(posedge core_clk) disable iff (!rst_b)
      (irq_edge_mode == `CIS_EDGE_TOGGLE && s_r.sync[1] != s_r.result)
      |=> comparator_irq;
   endproperty
   a_toggle_irq: assert property (p_toggle_irq) else $error("toggle missed");

   property p_none_irq;
      @(posedge core_clk) disable iff (!rst_b)
      (irq_edge_mode == `CIS_EDGE_NONE && !comparator_irq)
      |=> !comparator_irq;
   endproperty
   a_none_irq: assert property (p_none_irq) else $error("irq in none mode");

   property p_irq_clear;
      @(posedge core_clk) disable iff (!rst_b)
      (irq_clear && s_r.sync[1] == s_r.result)
      |=> !comparator_irq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("clear ignored");

   property p_set_wins;
      @(posedge core_clk) disable iff (!rst_b)
      (irq_clear && irq_edge_mode == `CIS_EDGE_TOGGLE && s_r.sync[1] != s_r.result)
      |=> comparator_irq;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("edge lost to clear");

   property p_irq_only_edge;
      @(posedge core_clk) disable iff (!rst_b)
      (!comparator_irq && s_r.sync[1] == s_r.result)
      |=> !comparator_irq;
   endproperty
   a_irq_only_edge: assert property (p_irq_only_edge) else $error("spurious irq");

   property p_pair_0_1;
      @(posedge core_clk) disable iff (!rst_b)
      (comparator_pair_select == `CIS_PAIR_0_1 && !negative_input_substitute_enable)
      |=> (positive_pin_sel == `CIS_PIN_ZERO && negative_pin_sel == `CIS_PIN_ONE);
   endproperty
   a_pair_0_1: assert property (p_pair_0_1) else $error("pair 0/1 wrong");

   property p_pair_0_2;
      @(posedge core_clk) disable iff (!rst_b)
      (comparator_pair_select == `CIS_PAIR_0_2 && !negative_input_substitute_enable)
      |=> (positive_pin_sel == `CIS_PIN_ZERO && negative_pin_sel == `CIS_PIN_TWO);
   endproperty
   a_pair_0_2: assert property (p_pair_0_2) else $error("pair 0/2 wrong");

   property p_pair_1_0;
      @(posedge core_clk) disable iff (!rst_b)
      (comparator_pair_select == `CIS_PAIR_1_0 && !negative_input_substitute_enable)
      |=> (positive_pin_sel == `CIS_PIN_ONE && negative_pin_sel == `CIS_PIN_ZERO);
   endproperty
   a_pair_1_0: assert property (p_pair_1_0) else $error("pair 1/0 wrong");

   property p_pair_default;
      @(posedge core_clk) disable iff (!rst_b)
      (comparator_pair_select > `CIS_PAIR_1_2 && !negative_input_substitute_enable)
      |=> (positive_pin_sel == `CIS_PIN_ZERO && negative_pin_sel == `CIS_PIN_ONE);
   endproperty
   a_pair_default: assert property (p_pair_default) else $error("undefined pair not 0/1");

   property p_neg_dedicated;
      @(posedge core_clk) disable iff (!rst_b)
      (!negative_input_substitute_enable || converter_enable || converter_channel_select > SE_LAST)
      |=> (negative_pin_sel <= `CIS_PIN_TWO);
   endproperty
   a_neg_dedicated: assert property (p_neg_dedicated) else $error("negative not a dedicated pin");

   property p_sub_keeps_pos;
      @(posedge core_clk) disable iff (!rst_b)
      (negative_input_substitute_enable && !converter_enable && comparator_pair_select == `CIS_PAIR_1_2)
      |=> (positive_pin_sel == `CIS_PIN_ONE);
   endproperty
   a_sub_keeps_pos: assert property (p_sub_keeps_pos) else $error("substitution moved positive");
endmodule // cis_comparator_input_select

// ### bench/tb_comparator_input_select.sv
`timescale 1ns/100ps
`include "cis_defs.svh"
module tb_comparator_input_select import cis_pkg::*;;
   logic       core_clk, rst_b, raw, sub_en, conv_en, clr, res, irq, nfc;
   logic [5:0] chan;
   logic [2:0] pair;
   logic [1:0] mode;
   logic [3:0] psel, nsel;
   int         errors, n_checks, cyc;
`define CHK(a,b) begin n_checks++; if ((a)!==(b)) begin errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
   cis_comparator_input_select dut (.core_clk(core_clk), .rst_b(rst_b), .comparator_raw(raw),
      .negative_input_substitute_enable(sub_en), .converter_enable(conv_en), .converter_channel_select(chan),
      .comparator_pair_select(pair), .irq_edge_mode(mode), .irq_clear(clr), .comparator_result(res),
      .comparator_irq(irq), .negative_from_converter(nfc), .positive_pin_sel(psel), .negative_pin_sel(nsel));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task print_verdict;
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         print_verdict;
      end
   end
   task pair_case(input logic [2:0] c, input logic [3:0] p, input logic [3:0] n);
      pair = c;
      step(2);
      `CHK(psel, p)
      `CHK(nsel, n)
      `CHK(nfc, 1'b0)
   endtask
   task sub_case(input logic s, input logic e, input logic [5:0] ch, input logic [3:0] n, input logic f);
      sub_en = s;
      conv_en = e;
      chan = ch;
      step(2);
      `CHK(nsel, n)
      `CHK(nfc, f)
   endtask
   // settle at the opposite level, clear, then make one edge
   task irq_case(input logic [1:0] m, input logic r, input logic x);
      mode = m;
      raw = ~r;
      step(6);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(1);
      `CHK(irq, 1'b0)
      `CHK(res, ~r)
      raw = r;
      step(6);
      `CHK(irq, x)
      `CHK(res, r)
   endtask
   // a new edge in the clear cycle keeps the flag, which then stands
   task clear_collide;
      mode = `CIS_EDGE_TOGGLE;
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      `CHK(irq, 1'b0)
      raw = ~raw;
      step(2);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(5);
      `CHK(irq, 1'b1)
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      `CHK(irq, 1'b0)
   endtask
   // reset mid-run with the input high: all clear, then a fresh edge
   task reset_case;
      raw = 1'b1;
      rst_b = 1'b0;
      step(1);
      `CHK({irq, res, nfc, psel, nsel}, 11'h000)
      rst_b = 1'b1;
      step(4);
      `CHK(res, 1'b1)
      `CHK(irq, 1'b1)
      `CHK({psel, nsel}, 8'h12)
   endtask
   initial begin
      {rst_b, raw, sub_en, conv_en, clr, chan, pair, mode} = '0;
      repeat (10) @(posedge core_clk);
      #1 rst_b = 1'b1;
      `CHK({irq, res, nfc}, 3'h0)
      pair_case(`CIS_PAIR_0_1, 4'h0, 4'h1);
      pair_case(`CIS_PAIR_0_2, 4'h0, 4'h2);
      pair_case(`CIS_PAIR_1_0, 4'h1, 4'h0);
      pair_case(3'h5, 4'h0, 4'h1);
      pair_case(`CIS_PAIR_1_2, 4'h1, 4'h2);
      sub_case(1'b1, 1'b0, 6'h0A, 4'hA, 1'b1);
      sub_case(1'b1, 1'b0, 6'h00, 4'h0, 1'b1);
      sub_case(1'b1, 1'b1, 6'h05, 4'h2, 1'b0);
      sub_case(1'b1, 1'b0, 6'h0B, 4'h2, 1'b0);
      sub_case(1'b0, 1'b0, 6'h05, 4'h2, 1'b0);
      irq_case(`CIS_EDGE_RISE, 1'b1, 1'b1);
      irq_case(`CIS_EDGE_RISE, 1'b0, 1'b0);
      irq_case(`CIS_EDGE_FALL, 1'b0, 1'b1);
      irq_case(`CIS_EDGE_FALL, 1'b1, 1'b0);
      irq_case(`CIS_EDGE_TOGGLE, 1'b1, 1'b1);
      irq_case(`CIS_EDGE_TOGGLE, 1'b0, 1'b1);
      irq_case(`CIS_EDGE_NONE, 1'b1, 1'b0);
      clear_collide;
      reset_case;
      print_verdict;
   end
endmodule // tb_comparator_input_select
